// ---- dcf_port_ctrl.sv ----
// dual-port buffer with configuration load path, fill flags and irq
// assumes every pin input except arst_n is synchronous to core_clk; port clocks are
// sampled and their rising edges act as one-cycle enables
//
// The address map and the plain strobed port are this design's own decisions.
`default_nettype none

module dcf_port_ctrl (
  input wire logic core_clk,
  input wire logic arst_n,
  // write port
  input wire logic write_clk,
  input wire logic wr_enable_n,
  input wire logic input_store_gate_n,
  input wire logic [dcf_pkg::DATA_W-1:0] wr_data,
  // read port
  input wire logic read_clk,
  input wire logic rd_enable_n,
  input wire logic out_enable_n,
  output logic [dcf_pkg::DATA_W-1:0] rd_data_out,
  output logic rd_data_oe_n,
  // shared
  input wire logic config_load_select,
  output logic empty_flag_n,
  output logic full_flag_n,
  output logic almost_empty_flag_n,
  output logic almost_full_flag_n,
  // register port
  input wire logic [dcf_pkg::BUS_AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq
);
  import dcf_pkg::*;

  // ==========================================================
  // reset release
  // arst_n may drop at any time; every flop below except the storage array clears at once, but
  // release is staged so no flop leaves reset a cycle before its neighbours
  // limitation: while the two stages fill, pin edges are not seen at all,
  // so the far side must hold its port clocks low for those cycles
  // trade-off: two cycles of dead time bought a clean, glitch-free release
  logic rst_meta_reg;
  logic rst_n_reg;

  // async assert, two-flop release so downstream sees a clean edge
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // ==========================================================
  // port clock edge detect
  // port clocks are plain samples of a pin, not real clock domains;
  // a pulse must stay high for at least one core_clk period to be seen
  // and low for one period between pulses, or an edge is lost silently
  // the sample flops clear to the idle low level, so a pin low at release gives no false edge;
  // a pin already high at release counts as a rising edge in the first cycle
  // limitation: port clocks faster than half of core_clk are not supported
  logic wclk_q_reg;
  logic rclk_q_reg;

  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      wclk_q_reg <= 1'b0;
      rclk_q_reg <= 1'b0;
    end else begin
      wclk_q_reg <= write_clk;
      rclk_q_reg <= read_clk;
    end
  end

  // strobes only on a rising edge with the enable low
  wire wr_edge = write_clk & ~wclk_q_reg;
  wire rd_edge = read_clk & ~rclk_q_reg;
  wire wr_go = wr_edge & ~wr_enable_n;
  wire rd_go = rd_edge & ~rd_enable_n;

  // ==========================================================
  // pointers and level
  // pointers carry one extra wrap bit so full and empty differ:
  // equal low bits with equal wrap bits mean empty, with differing wrap
  // bits full; the level is a plain modular difference of the two
  // hazard: a write and a read in one cycle both move, so the level is
  // unchanged, and neither is judged against the other's new value
  // refused accesses are judged on the level before the edge
  logic [PTR_W-1:0] wptr_reg;
  logic [PTR_W-1:0] rptr_reg;
  logic [PTR_W-1:0] level;
  logic is_empty;
  logic is_full;

  assign level = wptr_reg - rptr_reg;
  assign is_empty = (level == '0);
  assign is_full = (level == PTR_W'(DEPTH));

  // route each enabled strobe to memory or config
  dcf_access_t wr_acc;
  dcf_access_t rd_acc;
  assign wr_acc.mem = wr_go & config_load_select;
  assign wr_acc.cfg = wr_go & ~config_load_select;
  assign rd_acc.mem = rd_go & config_load_select;
  assign rd_acc.cfg = rd_go & ~config_load_select;

  // refused accesses still show up as status events
  wire wr_take = wr_acc.mem & ~is_full;
  wire rd_take = rd_acc.mem & ~is_empty;
  wire wr_refused = wr_acc.mem & is_full;
  wire rd_refused = rd_acc.mem & is_empty;

  // pointer moves even when the store is gated off
  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
    end else begin
      if (wr_take) begin
        wptr_reg <= wptr_reg + PTR_W'(1);
      end
      if (rd_take) begin
        rptr_reg <= rptr_reg + PTR_W'(1);
      end
    end
  end

  // ==========================================================
  // storage array
  // sixteen words of full data width; the array has no reset, so words
  // left from before a reset stay in place but sit behind the read pointer
  // a gated write leaves the old word where it was, so the location is
  // skipped rather than cleared
  // write and read of one address in one cycle cannot clash: a read
  // needs level above zero and a write needs it below sixteen
  logic [DATA_W-1:0] mem [DEPTH];
  wire [ADDR_W-1:0] waddr = wptr_reg[ADDR_W-1:0];
  wire [ADDR_W-1:0] raddr = rptr_reg[ADDR_W-1:0];

  // no reset on the array; a stale word is read back only from a location skipped by a gated write
  always_ff @(posedge core_clk) begin
    if (wr_take && !input_store_gate_n) begin
      mem[waddr] <= wr_data;
    end
  end

  // ==========================================================
  // offset registers, loaded from pins or from software
  // two offsets share one pin path; a write index and a separate read
  // index each toggle on every config access, so loads and reads both
  // walk almost-empty first, then almost-full
  // limitation: the indices are only cleared by reset, so a half-finished
  // load sequence must be completed by the user
  // only the low byte of the pin word is taken; upper bits are ignored
  logic [CFG_W-1:0] ae_ofs_reg;
  logic [CFG_W-1:0] af_ofs_reg;
  logic cfg_widx_reg;
  logic cfg_ridx_reg;

  wire bus_ae_wr = reg_wr && (reg_addr == AE_OFS_OFS);
  wire bus_af_wr = reg_wr && (reg_addr == AF_OFS_OFS);
  wire pin_ae_wr = wr_acc.cfg && (cfg_widx_reg == CFG_IDX_AE);
  wire pin_af_wr = wr_acc.cfg && (cfg_widx_reg == CFG_IDX_AF);
  wire [CFG_W-1:0] cfg_rd_word = (cfg_ridx_reg == CFG_IDX_AE) ? ae_ofs_reg : af_ofs_reg;

  // software wins a same-cycle clash; pin loads walk the set in order
  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ae_ofs_reg <= AE_OFS_RST;
      af_ofs_reg <= AF_OFS_RST;
      cfg_widx_reg <= CFG_IDX_AE;
      cfg_ridx_reg <= CFG_IDX_AE;
    end else begin
      if (bus_ae_wr) begin
        ae_ofs_reg <= reg_wdata[CFG_W-1:0];
      end else if (pin_ae_wr) begin
        ae_ofs_reg <= wr_data[CFG_W-1:0];
      end
      if (bus_af_wr) begin
        af_ofs_reg <= reg_wdata[CFG_W-1:0];
      end else if (pin_af_wr) begin
        af_ofs_reg <= wr_data[CFG_W-1:0];
      end
      if (wr_acc.cfg) begin
        cfg_widx_reg <= ~cfg_widx_reg;
      end
      if (rd_acc.cfg) begin
        cfg_ridx_reg <= ~cfg_ridx_reg;
      end
    end
  end

  // ==========================================================
  // read data path and output drive
  logic [DATA_W-1:0] q_reg;
  logic q_oe_n_reg;

  // output holds its last word between reads
  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      q_reg <= '0;
      q_oe_n_reg <= 1'b1;
    end else begin
      q_oe_n_reg <= out_enable_n;
      if (rd_take) begin
        q_reg <= mem[raddr];
      end else if (rd_acc.cfg) begin
        q_reg <= {{(DATA_W-CFG_W){1'b0}}, cfg_rd_word};
      end
    end
  end

  assign rd_data_out = q_reg;
  assign rd_data_oe_n = q_oe_n_reg;

  // ==========================================================
  // fill flags
  // all four flags come from one registered struct, so they change
  // together, one cycle after the pointers that they describe
  // almost-full compares against sixteen minus the offset; an offset
  // above sixteen wraps the limit and is not guarded against
  // all flags are active low, matching the pins they drive
  dcf_flags_t flags_reg;
  dcf_flags_t flags_next;
  wire [CFG_W-1:0] level_w = CFG_W'(level);
  wire [CFG_W-1:0] af_limit = CFG_W'(DEPTH) - af_ofs_reg;

  // flags trail the pointers by one cycle; they are outputs, not gates
  assign flags_next.empty_n = ~is_empty;
  assign flags_next.full_n = ~is_full;
  assign flags_next.aempty_n = ~(level_w <= ae_ofs_reg);
  assign flags_next.afull_n = ~(level_w >= af_limit);

  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      flags_reg <= FLAGS_RST;
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign empty_flag_n = flags_reg.empty_n;
  assign full_flag_n = flags_reg.full_n;
  assign almost_empty_flag_n = flags_reg.aempty_n;
  assign almost_full_flag_n = flags_reg.afull_n;

  // ==========================================================
  // interrupt status and mask
  // four sticky events, each cleared by writing a one to its bit
  // the emptied and filled events come from flag transitions, so a
  // buffer that stays empty across reset raises no spurious event
  // irq is built from the next status so it rises with the status bit
  logic [EV_W-1:0] status_reg;
  logic [EV_W-1:0] mask_reg;
  logic [EV_W-1:0] events;
  logic [EV_W-1:0] status_next;
  logic irq_reg;

  // falling edges of the active-low flags mark entry to empty / full
  assign events[EV_OVERFLOW] = wr_refused;
  assign events[EV_UNDERFLOW] = rd_refused;
  assign events[EV_EMPTIED] = flags_reg.empty_n & ~flags_next.empty_n;
  assign events[EV_FILLED] = flags_reg.full_n & ~flags_next.full_n;

  wire status_wr = reg_wr && (reg_addr == STATUS_OFS);
  wire mask_wr = reg_wr && (reg_addr == MASK_OFS);
  wire [EV_W-1:0] w1c = status_wr ? reg_wdata[EV_W-1:0] : '0;

  // a new event beats a clear landing in the same cycle
  assign status_next = (status_reg & ~w1c) | events;

  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      status_reg <= STATUS_RST;
      mask_reg <= MASK_RST;
      irq_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      if (mask_wr) begin
        mask_reg <= reg_wdata[EV_W-1:0];
      end
      irq_reg <= |(status_next & mask_reg);
    end
  end

  assign irq = irq_reg;

  // ==========================================================
  // register read port
  // the level word packs the five-bit count in the low bits and the
  // four flags above it, so one read shows count and flags together
  // reads have no side effects; clearing status needs an explicit write
  logic [31:0] rdata_reg;
  logic [31:0] rdata_mux;
  logic [31:0] level_word;

  assign level_word = (32'(level) << LVL_COUNT_LSB) | (32'(flags_reg) << LVL_FLAGS_LSB);

  // unmapped addresses read as zero
  always_comb begin
    rdata_mux = '0;
    unique case (reg_addr)
      STATUS_OFS: rdata_mux = 32'(status_reg);
      MASK_OFS: rdata_mux = 32'(mask_reg);
      AE_OFS_OFS: rdata_mux = 32'(ae_ofs_reg);
      AF_OFS_OFS: rdata_mux = 32'(af_ofs_reg);
      LEVEL_OFS: rdata_mux = level_word;
      default: rdata_mux = '0;
    endcase
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= reg_rd ? rdata_mux : 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_reg;

endmodule

`default_nettype wire

// ---- dcf_pkg.sv ----
// constants and types shared by the dual-port buffer control block
// assumes one core clock; port "clocks" arrive as plain synchronous inputs
`default_nettype none

package dcf_pkg;

  // ==========================================================
  // buffer geometry
  localparam int DATA_W = 36;
  localparam int CFG_W = 8;
  localparam int ADDR_W = 4;
  localparam int DEPTH = 16;
  localparam int PTR_W = ADDR_W + 1;
  localparam int CFG_REGS = 2;

  // ==========================================================
  // register bus, byte addresses
  localparam int BUS_AW = 8;
  localparam logic [BUS_AW-1:0] STATUS_OFS = 8'h00;
  localparam logic [BUS_AW-1:0] MASK_OFS = 8'h04;
  localparam logic [BUS_AW-1:0] AE_OFS_OFS = 8'h08;
  localparam logic [BUS_AW-1:0] AF_OFS_OFS = 8'h0C;
  localparam logic [BUS_AW-1:0] LEVEL_OFS = 8'h10;

  // ==========================================================
  // status / mask bit positions
  localparam int EV_W = 4;
  localparam int EV_OVERFLOW = 0;
  localparam int EV_UNDERFLOW = 1;
  localparam int EV_EMPTIED = 2;
  localparam int EV_FILLED = 3;

  // level register field positions
  localparam int LVL_COUNT_LSB = 0;
  localparam int LVL_FLAGS_LSB = 8;

  // config register indices, in load order
  localparam logic CFG_IDX_AE = 1'b0;
  localparam logic CFG_IDX_AF = 1'b1;

  // ==========================================================
  // reset values
  localparam logic [CFG_W-1:0] AE_OFS_RST = 8'h02;
  localparam logic [CFG_W-1:0] AF_OFS_RST = 8'h02;
  localparam logic [EV_W-1:0] MASK_RST = 4'h0;
  localparam logic [EV_W-1:0] STATUS_RST = 4'h0;

  // active-low fill flags, carried together
  typedef struct packed {
    logic afull_n;
    logic aempty_n;
    logic full_n;
    logic empty_n;
  } dcf_flags_t;

  localparam dcf_flags_t FLAGS_RST = '{afull_n: 1'b1, aempty_n: 1'b0,
                                       full_n: 1'b1, empty_n: 1'b0};

  // one port access, decoded from the pin strobes
  typedef struct packed {
    logic mem;
    logic cfg;
  } dcf_access_t;

endpackage

`default_nettype wire

// ---- dcf_port_ctrl_asserts.sv ----
// checker for the dual-port buffer control block
// assumes only the block's top ports; a level copy is rebuilt from the pins
`default_nettype none

module dcf_port_ctrl_asserts (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic write_clk,
  input wire logic wr_enable_n,
  input wire logic read_clk,
  input wire logic rd_enable_n,
  input wire logic out_enable_n,
  input wire logic config_load_select,
  input wire logic [dcf_pkg::DATA_W-1:0] rd_data_out,
  input wire logic rd_data_oe_n,
  input wire logic empty_flag_n,
  input wire logic full_flag_n,
  input wire logic almost_empty_flag_n,
  input wire logic almost_full_flag_n,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  import dcf_pkg::*;
  logic wc_reg;
  logic rc_reg;
  logic [5:0] lvl_reg;
  logic wr_take;
  logic rd_take;
  logic [5:0] lvl_next;

  // ==========================================================
  // port edge decode and fill level copy, refused accesses do not count
  assign wr_take = write_clk & ~wc_reg & ~wr_enable_n;
  assign rd_take = read_clk & ~rc_reg & ~rd_enable_n;
  assign lvl_next = lvl_reg
    + 6'(wr_take & config_load_select & (lvl_reg != 6'h10))
    - 6'(rd_take & config_load_select & (lvl_reg != 6'h00));

  // previous pin samples; pins are low at reset release
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wc_reg <= 1'b0;
      rc_reg <= 1'b0;
      lvl_reg <= 6'h00;
    end else begin
      wc_reg <= write_clk;
      rc_reg <= read_clk;
      lvl_reg <= lvl_next;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  // ==========================================================
  // flags lag the pointers by one cycle
  chk_empty_level: assert property (empty_flag_n == ($past(lvl_reg) != 6'h00))
    else $error("empty flag does not match level");
  chk_full_level: assert property (full_flag_n == ($past(lvl_reg) != 6'h10))
    else $error("full flag does not match level");
  chk_aempty_zero: assert property ($past(lvl_reg) == 6'h00 |-> !almost_empty_flag_n)
    else $error("almost empty flag high while empty");
  chk_afull_top: assert property ($past(lvl_reg) == 6'h10 |-> !almost_full_flag_n)
    else $error("almost full flag high while full");
  chk_flag_excl: assert property (!(!full_flag_n && !empty_flag_n))
    else $error("full and empty both asserted");
  chk_oe_follow: assert property ($changed(out_enable_n) |=> rd_data_oe_n == $past(out_enable_n))
    else $error("output enable not followed");
  chk_read_hold: assert property (!rd_take |=> $stable(rd_data_out))
    else $error("read data moved without a read");
  chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("register data without a read");

  cov_full: cover property (!full_flag_n);
  cov_cfg_read: cover property (rd_take && !config_load_select);
  cov_refused: cover property (wr_take && lvl_reg == 6'h10);
endmodule

bind dcf_port_ctrl dcf_port_ctrl_asserts u_chk (.*);

`default_nettype wire

// ---- dcf_partner.sv ----
// producer and consumer logic model: makes the port clock pulses
// assumes requests arrive as one-cycle pulses synchronous to core_clk
`default_nettype none

module dcf_partner (
  input wire logic core_clk,
  input wire logic slow,
  input wire logic wr_go,
  input wire logic rd_go,
  output logic write_clk,
  output logic read_clk
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] wcnt_reg = 2'h0;
  logic [1:0] rcnt_reg = 2'h0;

  // ==========================================================
  // port clocks rise only on request, high one or two cycles, then low
  always_ff @(posedge core_clk) begin
    wcnt_reg <= wr_go ? (slow ? 2'h2 : 2'h1) : wcnt_reg - 2'(wcnt_reg != 2'h0);
    rcnt_reg <= rd_go ? (slow ? 2'h2 : 2'h1) : rcnt_reg - 2'(rcnt_reg != 2'h0);
  end
  assign write_clk = (wcnt_reg != 2'h0);
  assign read_clk = (rcnt_reg != 2'h0);
endmodule

`default_nettype wire

// ---- dcf_port_ctrl_bench.sv ----
// self-checking bench for the dual-port buffer control block
// assumes package, design, checker and partner files compiled first
`default_nettype none

module dcf_port_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import dcf_pkg::*;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic write_clk, read_clk, rd_data_oe_n, irq, wr_go = 0, rd_go = 0, slow = 0;
  logic wr_enable_n = 1, input_store_gate_n = 0, rd_enable_n = 1, out_enable_n = 1;
  logic config_load_select = 1, reg_wr = 0, reg_rd = 0;
  logic empty_flag_n, full_flag_n, almost_empty_flag_n, almost_full_flag_n;
  logic [35:0] wr_data = 0, rd_data_out, rexp = 0;
  logic [35:0] mem [16];
  logic [7:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata, x = 30359;
  int wp = 0, rp = 0, lvl = 0, ae = 2, af = 2, wi = 0, ci = 0, st = 0, mask = 0;
  int err_count = 0, n_checks = 0;

  dcf_port_ctrl u_dut (.*);
  dcf_partner u_far (.*);

  // ==========================================================
  // clock, random source and comparison helpers
  always #20 core_clk = ~core_clk;

  function automatic logic [31:0] rnd();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  task cmp(input string n, input logic [35:0] e, input logic [35:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask

  task chk_state();
    cmp("flags", 36'({lvl < 16 - af, lvl > ae, lvl != 16, lvl != 0}),
        36'({almost_full_flag_n, almost_empty_flag_n, full_flag_n, empty_flag_n}));
    cmp("irq", 36'((st & mask) != 0), 36'(irq));
  endtask

  task stop_test();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================================
  // register bus cycles
  task rw(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask

  task rr(input logic [7:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    cmp("reg read", 36'(e), 36'(reg_rdata));
    @(posedge core_clk);
  endtask

  // one port access, then model update and compare; offsets kept below 16
  task op(input logic w, input logic sel, input logic gate_off);
    logic [35:0] d;
    d = 36'({rnd(), rnd()});
    if (!sel) d[7:4] = 4'h0;
    wr_data <= d;
    config_load_select <= sel;
    input_store_gate_n <= gate_off;
    wr_enable_n <= !w;
    rd_enable_n <= w;
    wr_go <= w;
    rd_go <= !w;
    @(posedge core_clk);
    wr_go <= 1'b0;
    rd_go <= 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
    if (!sel) begin
      if (w && wi == 0) ae = int'(d[7:0]);
      else if (w) af = int'(d[7:0]);
      else rexp = 36'(ci ? af : ae);
      if (w) wi ^= 1;
      else ci ^= 1;
    end else if (w && lvl == 16) st |= 1;
    else if (w) begin
      if (!gate_off) mem[wp] = d;
      wp = (wp + 1) % 16;
      lvl++;
      if (lvl == 16) st |= 8;
    end else if (lvl == 0) st |= 2;
    else begin
      rexp = mem[rp];
      rp = (rp + 1) % 16;
      lvl--;
      if (lvl == 0) st |= 4;
    end
    cmp("read data", rexp, rd_data_out);
    chk_state();
    @(posedge core_clk);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (12) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    cmp("idle oe", 36'h1, 36'(rd_data_oe_n));
    chk_state();
    @(posedge core_clk);
    mask = 15;
    rw(MASK_OFS, 32'h0000_000f);
    op(1'b0, 1'b1, 1'b0);
    rr(STATUS_OFS, 32'h0000_0002);
    rw(STATUS_OFS, 32'h0000_000f);
    st = 0;
    for (int i = 0; i < 17; i++) begin
      slow <= i[0];
      op(1'b1, 1'b1, 1'b0);
    end
    rr(LEVEL_OFS, 32'h0000_0510);
    for (int i = 0; i < 16; i++) op(1'b0, 1'b1, 1'b0);
    for (int i = 0; i < 6; i++) op(i < 3, 1'b1, i == 1);
    rr(STATUS_OFS, 32'(st));
    rw(STATUS_OFS, 32'h0000_000f);
    st = 0;
    for (int i = 0; i < 4; i++) op(i < 2, 1'b0, 1'b0);
    rr(AE_OFS_OFS, 32'(ae));
    rr(AF_OFS_OFS, 32'(af));
    rr(8'h20, 32'h0000_0000);
    rw(AE_OFS_OFS, 32'h0000_0009);
    ae = 9;
    for (int i = 0; i < 32; i++) op(i < 16, 1'b1, 1'b0);
    out_enable_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    cmp("drive oe", 36'h0, 36'(rd_data_oe_n));
    stop_test();
  end

  // hang guard
  initial begin
    repeat (30000) @(posedge core_clk);
    err_count++;
    stop_test();
  end
endmodule

`default_nettype wire
